// *** hw/swd_pkg.sv ***
package swd_pkg;

  // ---------------------------------------------------------------
  // clock and oscillator
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int OSC_HZ = 10240;
  localparam int TICK_DIV = CLK_HZ / OSC_HZ;
  localparam int DIV_W = 12;
  localparam int MS_PER_S = 1000;

  // ---------------------------------------------------------------
  // internal oscillator periods in ms
  // ---------------------------------------------------------------
  localparam int TMO_SHORT_MS = 100;
  localparam int TMO_LONG_MS = 1600;
  localparam int RST_SHORT_MS = 50;
  localparam int RST_LONG_MS = 200;

  // ---------------------------------------------------------------
  // periods in timebase ticks
  // ---------------------------------------------------------------
  localparam int CNT_W = 15;
  localparam logic [CNT_W-1:0] INT_TMO_SHORT =
    CNT_W'(TMO_SHORT_MS * OSC_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] INT_TMO_LONG =
    CNT_W'(TMO_LONG_MS * OSC_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] INT_RST_SHORT =
    CNT_W'(RST_SHORT_MS * OSC_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] INT_RST_LONG =
    CNT_W'(RST_LONG_MS * OSC_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] EXT_TMO_SHORT = 15'h0400;
  localparam logic [CNT_W-1:0] EXT_TMO_LONG = 15'h1000;
  localparam logic [CNT_W-1:0] EXT_RST_SHORT = 15'h0200;
  localparam logic [CNT_W-1:0] EXT_RST_LONG = 15'h0800;

  // ---------------------------------------------------------------
  // synchronised pin bus layout
  // ---------------------------------------------------------------
  localparam int PIN_W = 7;
  localparam int PIN_KICK = 0;
  localparam int PIN_FLOAT = 1;
  localparam int PIN_SUPPLY = 2;
  localparam int PIN_SEL = 3;
  localparam int PIN_TBIN = 4;
  localparam int PIN_ADJ = 5;
  localparam int PIN_LONG = 6;
  localparam logic [PIN_W-1:0] PIN_RST = 7'h00;

  // ---------------------------------------------------------------
  // timer states
  // ---------------------------------------------------------------
  typedef enum logic {
    ST_TIMING,
    ST_PULSE
  } swd_state_e;

endpackage : swd_pkg

// *** hw/swd_sync.sv ***
module swd_sync
  import swd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic [PIN_W-1:0] pin_in,
  output logic [PIN_W-1:0] pin_sync
);

  logic [PIN_W-1:0] meta_q;
  logic [PIN_W-1:0] sync_q;

  // ---------------------------------------------------------------
  // two-stage synchroniser per pin
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < PIN_W; i++)
    begin : g_bit
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_q[i] <= PIN_RST[i];
          sync_q[i] <= PIN_RST[i];
        end
        else
        begin
          meta_q[i] <= pin_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign pin_sync = sync_q;

endmodule : swd_sync

// *** hw/swd_tick.sv ***
module swd_tick
  import swd_pkg::*;
#(
  parameter logic [DIV_W-1:0] DIV = DIV_W'(TICK_DIV)
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // timebase source
  input wire logic ext_mode,
  input wire logic ext_clk_s,
  // tick
  output logic tick
);

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic ext_prev_q;
  logic ext_prev_d;
  logic tick_q;
  logic tick_d;

  // ---------------------------------------------------------------
  // internal divider or external clock rising edge
  // ---------------------------------------------------------------
  always_comb
  begin
    ext_prev_d = ext_clk_s;
    div_d = div_q;
    tick_d = 1'b0;
    if (ext_mode)
    begin
      div_d = '0;
      tick_d = ext_clk_s && !ext_prev_q;
    end
    else if (div_q == DIV - 12'h001)
    begin
      div_d = '0;
      tick_d = 1'b1;
    end
    else
    begin
      div_d = div_q + 12'h001;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= '0;
      ext_prev_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      ext_prev_q <= ext_prev_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : swd_tick

// *** hw/swd_watchdog.sv ***
// Operation
// - timeout with no kick edge drives reset low, 35ms or 140ms minimum
// - adjustable variant uses long period of at least 1 s after reset
// - short 70ms period starts after first kick edge once reset released
// - non-adjustable variant always uses one period of at least 1 s
// - count restarts when reset output returns inactive
// - every kick edge before expiry clears and restarts the count
// - constant kick level gives repeated resets about every 1.6 s
// - floating kick input switches the watchdog off
// - timer held disabled while supply low or below battery
// - adjustable flag goes low at expiry, high at next kick edge
// - flag forced high while supply low or below battery
// - external clock: 1024 and 4096 clock periods, reset 512 or 2048
// - internal oscillator fixes reset length at 35ms or 140ms minimum
// - timebase input picks 100ms or 1.6 s normal period internally
// - period right after reset is at least one second internally
// - internal timebase runs at nominal 10.24 kHz
// - kick input ignored in battery backup mode
module swd_watchdog
  import swd_pkg::*;
#(
  parameter logic [DIV_W-1:0] TICK_DIVIDE = DIV_W'(TICK_DIV)
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // kick from host
  input wire logic watchdog_kick_input,
  input wire logic kick_floating,
  // supply monitor
  input wire logic supply_ok,
  // timebase pins
  input wire logic timebase_select,
  input wire logic timebase_input,
  // variant straps
  input wire logic variant_adjustable,
  input wire logic variant_long_reset,
  // outputs
  output logic reset_out_n,
  output logic timeout_flag_output
);

  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] pins_s;
  logic kick_s;
  logic float_s;
  logic supply_s;
  logic sel_s;
  logic tbin_s;
  logic adj_s;
  logic long_var_s;
  logic enabled;
  logic ext_mode;
  logic tick;
  logic kick_edge;
  logic [CNT_W-1:0] tmo_lim;
  logic [CNT_W-1:0] rst_lim;
  logic expire;

  swd_state_e state_q;
  swd_state_e state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic long_q;
  logic long_d;
  logic kick_prev_q;
  logic kick_prev_d;
  logic rst_n_q;
  logic rst_n_d;
  logic flag_q;
  logic flag_d;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  assign pins = {variant_long_reset, variant_adjustable, timebase_input,
                 timebase_select, supply_ok, kick_floating,
                 watchdog_kick_input};

  swd_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(pins),
    .pin_sync(pins_s)
  );

  assign kick_s = pins_s[PIN_KICK];
  assign float_s = pins_s[PIN_FLOAT];
  assign supply_s = pins_s[PIN_SUPPLY];
  assign sel_s = pins_s[PIN_SEL];
  assign tbin_s = pins_s[PIN_TBIN];
  assign adj_s = pins_s[PIN_ADJ];
  assign long_var_s = pins_s[PIN_LONG];

  // ---------------------------------------------------------------
  // timebase
  // ---------------------------------------------------------------
  assign ext_mode = adj_s && !sel_s;

  swd_tick #(
    .DIV(TICK_DIVIDE)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .ext_mode(ext_mode),
    .ext_clk_s(tbin_s),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // period selection
  // ---------------------------------------------------------------
  function automatic logic [CNT_W-1:0] sel_tmo(
    input logic adj,
    input logic ext,
    input logic tbin,
    input logic long_per
  );
    logic [CNT_W-1:0] lim;
    lim = INT_TMO_LONG;
    if (adj && ext)
      lim = long_per ? EXT_TMO_LONG : EXT_TMO_SHORT;
    else if (adj && !long_per && !tbin)
      lim = INT_TMO_SHORT;
    else if (adj)
      lim = INT_TMO_LONG;
    return lim;
  endfunction : sel_tmo

  function automatic logic [CNT_W-1:0] sel_rst(
    input logic ext,
    input logic long_var
  );
    logic [CNT_W-1:0] lim;
    if (ext)
      lim = long_var ? EXT_RST_LONG : EXT_RST_SHORT;
    else
      lim = long_var ? INT_RST_LONG : INT_RST_SHORT;
    return lim;
  endfunction : sel_rst

  assign tmo_lim = sel_tmo(adj_s, ext_mode, tbin_s, long_q);
  assign rst_lim = sel_rst(ext_mode, long_var_s);

  // ---------------------------------------------------------------
  // kick edge and enable
  // ---------------------------------------------------------------
  assign enabled = supply_s && !float_s;
  assign kick_edge = kick_s ^ kick_prev_q;
  assign expire = (state_q == ST_TIMING) && enabled && !kick_edge &&
                  tick && (cnt_q >= tmo_lim - 15'h0001);

  // ---------------------------------------------------------------
  // timer state machine
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    long_d = long_q;
    rst_n_d = rst_n_q;
    flag_d = flag_q;
    kick_prev_d = kick_s;
    if (!enabled)
    begin
      state_d = ST_TIMING;
      cnt_d = '0;
      long_d = 1'b1;
      rst_n_d = 1'b1;
      flag_d = 1'b1;
    end
    else
    begin
      unique case (state_q)
        ST_TIMING:
        begin
          if (kick_edge)
          begin
            cnt_d = '0;
            flag_d = 1'b1;
            long_d = 1'b0;
          end
          else if (expire)
          begin
            state_d = ST_PULSE;
            cnt_d = '0;
            rst_n_d = 1'b0;
            flag_d = !adj_s;
            long_d = 1'b1;
          end
          else if (tick)
          begin
            cnt_d = cnt_q + 15'h0001;
          end
        end
        ST_PULSE:
        begin
          if (kick_edge)
            flag_d = 1'b1;
          if (tick)
          begin
            if (cnt_q == rst_lim - 15'h0001)
            begin
              state_d = ST_TIMING;
              cnt_d = '0;
              rst_n_d = 1'b1;
            end
            else
            begin
              cnt_d = cnt_q + 15'h0001;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_TIMING;
      cnt_q <= '0;
      long_q <= 1'b1;
      kick_prev_q <= 1'b0;
      rst_n_q <= 1'b1;
      flag_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      long_q <= long_d;
      kick_prev_q <= kick_prev_d;
      rst_n_q <= rst_n_d;
      flag_q <= flag_d;
    end
  end

  assign reset_out_n = rst_n_q;
  assign timeout_flag_output = flag_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seq_expire;
    expire;
  endsequence

  sequence seq_pulse_start;
    !rst_n_q && (state_q == ST_PULSE) && (cnt_q == '0);
  endsequence

  chk_expire_pulse: assert property (
    seq_expire |=> seq_pulse_start
  ) else $error("expiry did not start a reset pulse");

  chk_long_after: assert property (
    seq_expire |=> long_q ##1 (long_q || kick_edge || !enabled)
  ) else $error("long period not restored after reset");

  chk_short_switch: assert property (
    enabled && (state_q == ST_TIMING) && kick_edge |=> !long_q
  ) else $error("kick edge did not select short period");

  chk_fixed_period: assert property (
    !adj_s |-> (tmo_lim == INT_TMO_LONG)
  ) else $error("fixed variant used a wrong period");

  chk_release_restart: assert property (
    $rose(rst_n_q) |-> (cnt_q == '0) && (state_q == ST_TIMING)
  ) else $error("count not restarted at reset release");

  chk_kick_restart: assert property (
    enabled && (state_q == ST_TIMING) && kick_edge |=>
      (cnt_q == '0) && rst_n_q
  ) else $error("kick edge did not restart count");

  chk_float_off: assert property (
    float_s |=> rst_n_q && (cnt_q == '0)
  ) else $error("floating kick did not stop watchdog");

  chk_timer_disabled: assert property (
    !supply_s [*2] |-> rst_n_q && (cnt_q == '0) && long_q
  ) else $error("timer ran while supply low");

  chk_flag_low: assert property (
    (seq_expire and adj_s) |=> !flag_q
  ) else $error("flag not low after expiry");

  chk_flag_rise: assert property (
    enabled && kick_edge |=> flag_q
  ) else $error("flag not released by kick edge");

  chk_flag_forced: assert property (
    !supply_s |=> flag_q
  ) else $error("flag not forced high on low supply");

  chk_pulse_length: assert property (
    $rose(rst_n_q) && $past(enabled) |->
      ($past(cnt_q) == $past(rst_lim) - 15'h0001)
  ) else $error("reset pulse length wrong");

  chk_tick_count: assert property (
    enabled && (state_q == ST_TIMING) && !kick_edge && !tick |=>
      $stable(cnt_q)
  ) else $error("count moved without a tick");

endmodule : swd_watchdog

// *** tb/swd_host.sv ***
module swd_host (
  // clock
  input wire logic clk,
  // control from bench
  input wire logic go,
  input wire logic [15:0] gap,
  // kick pin
  output logic kick
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] cnt_q;

  initial
  begin
    kick = 1'b0;
    cnt_q = 16'h0000;
  end

  // -------------------------------------------------------------
  // toggle the kick pin every gap cycles while enabled
  // -------------------------------------------------------------
  always @(negedge clk)
  begin
    if (!go)
      cnt_q <= 16'h0000;
    else if (cnt_q >= gap - 16'h0001)
    begin
      cnt_q <= 16'h0000;
      kick <= ~kick;
    end
    else
      cnt_q <= cnt_q + 16'h0001;
  end
endmodule : swd_host

// *** tb/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import swd_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic kick;
  logic kick_floating = 1'b0;
  logic supply_ok = 1'b1;
  logic timebase_select = 1'b0;
  logic timebase_input = 1'b0;
  logic variant_adjustable = 1'b1;
  logic variant_long_reset = 1'b0;
  logic reset_out_n;
  logic timeout_flag_output;
  logic go = 1'b0;
  logic [15:0] gap = 16'h0E10;
  logic [1:0] tb_cnt = 2'b00;
  logic tb_run = 1'b1;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_pulse = 0;

  // -------------------------------------------------------------
  // clock, external timebase of four clocks, watchdog
  // -------------------------------------------------------------
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  always @(negedge clk)
  begin
    tb_cnt <= tb_cnt + 2'b01;
    timebase_input <= tb_cnt[1] & tb_run;
  end

  always @(negedge reset_out_n)
    n_pulse++;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 90000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  swd_host host (
    .clk(clk),
    .go(go),
    .gap(gap),
    .kick(kick)
  );

  swd_watchdog #(
    .TICK_DIVIDE(DIV_W'(4))
  ) DUT (
    .clk(clk),
    .rst(rst),
    .watchdog_kick_input(kick),
    .kick_floating(kick_floating),
    .supply_ok(supply_ok),
    .timebase_select(timebase_select),
    .timebase_input(timebase_input),
    .variant_adjustable(variant_adjustable),
    .variant_long_reset(variant_long_reset),
    .reset_out_n(reset_out_n),
    .timeout_flag_output(timeout_flag_output)
  );

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_rng(input string what, input int lo, input int hi,
                         input int got);
    num_checks++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wait_for(input logic lvl, input int lim, output int n);
    n = 0;
    while (reset_out_n !== lvl && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_for

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_first_period();
    int n;
    wait_for(1'b0, 20000, n);
    chk_rng("long period", 16376, 16404, n);
    chk_bit("flag at expiry", 1'b0, timeout_flag_output);
    wait_for(1'b1, 3000, n);
    chk_rng("short reset", 2040, 2064, n);
  endtask : t_first_period

  task automatic t_short_period();
    int n;
    int p;
    p = n_pulse;
    go = 1'b1;
    @(kick);
    repeat (6) @(negedge clk);
    chk_bit("flag after kick", 1'b1, timeout_flag_output);
    repeat (4) @(kick);
    variant_long_reset = 1'b1;
    go = 1'b0;
    chk_rng("pulses while kicked", p, p, n_pulse);
    wait_for(1'b0, 6000, n);
    chk_rng("short period", 4088, 4116, n);
    wait_for(1'b1, 9000, n);
    chk_rng("long reset", 8184, 8216, n);
  endtask : t_short_period

  task automatic t_internal();
    int n;
    tb_run = 1'b0;
    timebase_select = 1'b1;
    variant_long_reset = 1'b0;
    gap = 16'h0008;
    repeat (8) @(negedge clk);
    go = 1'b1;
    @(kick);
    go = 1'b0;
    wait_for(1'b0, 6000, n);
    chk_rng("internal period", 4088, 4116, n);
    chk_bit("flag internal", 1'b0, timeout_flag_output);
    wait_for(1'b1, 3000, n);
    chk_rng("internal reset", 2040, 2064, n);
    variant_adjustable = 1'b0;
    go = 1'b1;
    @(kick);
    go = 1'b0;
    wait_for(1'b0, 6000, n);
    chk_rng("fixed period", 6000, 6000, n);
  endtask : t_internal

  task automatic t_disable();
    int p;
    int n;
    variant_adjustable = 1'b1;
    wait_for(1'b0, 40, n);
    chk_rng("cut period", 1, 12, n);
    supply_ok = 1'b0;
    repeat (8) @(negedge clk);
    chk_bit("flag supply low", 1'b1, timeout_flag_output);
    chk_bit("reset supply low", 1'b1, reset_out_n);
    supply_ok = 1'b1;
    kick_floating = 1'b1;
    p = n_pulse;
    repeat (20000) @(negedge clk);
    chk_rng("pulses floating", p, p, n_pulse);
  endtask : t_disable

  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_first_period();
    t_short_period();
    t_internal();
    t_disable();
    end_of_test();
  end
endmodule : tb_top
